/* File: design/ssp_serial_port.v */
// radio serial data port: asynchronous and synchronous serial modes,
// general pin function routing and an apb register slave.
// assumes modem signals arrive on clk; pin 0 input comes from outside.
//
// Notes on behaviour
// - format 3 selects async mode, pin0 TX input
// - async bypasses packet handler, FIFO, coding, MSK
// - serial RX goes to any selected pin
// - async TX sampled at eight times rate
// - async RX raw level, eight samples per bit
// - format 1 selects sync mode with bit clock
// - sync TX pin0 becomes input while transmitting
// - sync TX latency is eight bit periods
// - sync RX data appears nine bits after start
// - sync word mode chooses hardware preamble handling
// - with sync hardware, address filtering unavailable
// - with packet handling, host sees payload only
// - pins may carry two-bit hard symbol
// - symbol strobe high half a symbol period
// - function code 29 selects symbol strobe
// - function selects pin0 direction, low means input
`timescale 1ns/1ps
`include "ssp_defines.vh"

module ssp_serial_port (
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // radio state and demodulator
  input  wire        tx_active,
  input  wire        rx_active,
  input  wire        rx_raw_level,
  input  wire [1:0]  rx_hard_sym,
  input  wire        ph_payload_go,
  // modulator side
  output wire        mod_tx_bit,
  output wire        mod_tx_strobe,
  // packet engine steering
  output wire        pkt_handler_bypass,
  output wire        fifo_bypass,
  output wire        coding_allowed,
  output wire        msk_allowed,
  output wire        preamble_sync_hw,
  output wire        addr_filter_allowed,
  // general pins
  input  wire        general_pin_0_in,
  output wire        general_pin_0_out,
  output wire        pin0_drive_enable_n,
  output wire        general_pin_1_out,
  output wire        pin1_drive_enable_n,
  output wire        general_pin_2_out,
  output wire        pin2_drive_enable_n
);

  // configuration registers
  reg  [1:0]  packet_format_select_q;   // serial mode choice
  reg  [2:0]  sync_word_mode_q;         // preamble/sync handling
  reg  [5:0]  pin_sel_q [0:2];          // per-pin function select
  reg  [15:0] rate_div_q;               // clk cycles per eighth bit

  // apb answer flops
  reg  [31:0] prdata_q;
  reg         pready_q;
  reg         pslverr_q;

  // pin 0 synchroniser
  reg         pin0_s1_q;                // first stage, read only by s2
  reg         pin0_s2_q;                // safe to use

  // datapath flops
  reg  [7:0]  tx_line_q;                // sync tx latency line
  reg  [8:0]  rx_line_q;                // sync rx latency line
  reg  [3:0]  rx_cnt_q;                 // bits since reception start
  reg         sync_rx_q;                // sync rx bit on pin
  reg         async_rx_q;               // quantised raw rx level
  reg         bitclk_q;                 // bit clock to the host
  reg  [1:0]  hard_q;                   // hard symbol on pins
  reg         symtick_q;                // symbol strobe on pins
  reg         mod_bit_q;
  reg         mod_strobe_q;
  reg         bypass_q;
  reg         fifo_bypass_q;
  reg         coding_q;
  reg         msk_q;
  reg         sync_hw_q;
  reg         addr_q;
  reg  [2:0]  pin_out_q;
  reg  [2:0]  pin_oe_n_q;

  // tick generator outputs
  wire        eighth_tick;
  wire [2:0]  phase;
  wire [2:0]  ph_n;                     // phase after this tick

  // mode decode
  wire        async_mode;
  wire        sync_mode;
  wire        serial_mode;
  wire        sync_hw;
  wire        pin0_is_input;
  wire        gate_open;
  wire        rising_tick;
  wire        falling_tick;
  wire        rx_valid;
  wire        apb_setup;
  wire        apb_write;
  reg  [31:0] rd_mux;
  reg         rd_hit;

  assign async_mode  = (packet_format_select_q == `SSP_FMT_ASYNC);
  assign sync_mode   = (packet_format_select_q == `SSP_FMT_SYNC);
  assign serial_mode = async_mode | sync_mode;
  assign sync_hw     = sync_mode & (sync_word_mode_q != 3'h0);
  // pin 0 takes host tx data whenever a serial transmit runs
  assign pin0_is_input = serial_mode & tx_active;
  // with hardware sync the host clock waits for payload start
  assign gate_open   = ~sync_hw | ph_payload_go;
  assign ph_n        = phase + 3'h1;
  assign rising_tick  = eighth_tick & (ph_n == 3'h4);
  assign falling_tick = eighth_tick & (ph_n == 3'h0);
  assign rx_valid    = (rx_cnt_q == `SSP_RX_CNT_FULL);

  // eighth-bit timebase shared by both serial modes
  ssp_tick_gen u_tick (
    .clk           (clk),
    .reset_n       (reset_n),
    .enable        (serial_mode),
    .div           (rate_div_q),
    .eighth_tick_q (eighth_tick),
    .phase_q       (phase)
  );

  // two flops before anything looks at the pin
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin0_s1_q <= 1'b0;
      pin0_s2_q <= 1'b0;
    end else begin
      pin0_s1_q <= general_pin_0_in;
      pin0_s2_q <= pin0_s1_q;
    end
  end

  // apb: setup cycle raises pready for exactly the first access cycle
  assign apb_setup = psel & ~penable & ~pready_q;
  assign apb_write = psel & penable & pwrite & pready_q;

  // read mux and address decode
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `SSP_OFF_CTRL: begin
        rd_mux[`SSP_CTRL_FMT_MSB:`SSP_CTRL_FMT_LSB] = packet_format_select_q;
        rd_mux[`SSP_CTRL_SWM_MSB:`SSP_CTRL_SWM_LSB] = sync_word_mode_q;
      end
      `SSP_OFF_PINCFG: begin
        rd_mux[5:0]   = pin_sel_q[0];
        rd_mux[13:8]  = pin_sel_q[1];
        rd_mux[21:16] = pin_sel_q[2];
      end
      `SSP_OFF_RATE: begin
        rd_mux[`SSP_RATE_MSB:0] = rate_div_q;
      end
      `SSP_OFF_STATUS: begin
        // live block state for software
        rd_mux[1:0] = packet_format_select_q;
        rd_mux[2]   = tx_active;
        rd_mux[3]   = rx_active;
        rd_mux[4]   = rx_valid;
        rd_mux[5]   = pin0_is_input;
        rd_mux[6]   = sync_hw;
        rd_mux[7]   = bitclk_q;
      end
      default: begin
        // unmapped: zero data and an error answer
        rd_hit = 1'b0;
      end
    endcase
  end

  // apb answer and register writes
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_q               <= 1'b0;
      prdata_q               <= 32'h0000_0000;
      pslverr_q              <= 1'b0;
      packet_format_select_q <= `SSP_RST_FMT;
      sync_word_mode_q       <= `SSP_RST_SWM;
      pin_sel_q[0]           <= `SSP_RST_PINSEL;
      pin_sel_q[1]           <= `SSP_RST_PINSEL;
      pin_sel_q[2]           <= `SSP_RST_PINSEL;
      rate_div_q             <= `SSP_RST_RATE;
    end else begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup & ~rd_hit;
      if (apb_setup) begin
        // reads return zero on writes, data only for reads
        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      end
      if (apb_write) begin
        case (paddr)
          `SSP_OFF_CTRL: begin
            packet_format_select_q <= pwdata[`SSP_CTRL_FMT_MSB:`SSP_CTRL_FMT_LSB];
            sync_word_mode_q       <= pwdata[`SSP_CTRL_SWM_MSB:`SSP_CTRL_SWM_LSB];
          end
          `SSP_OFF_PINCFG: begin
            pin_sel_q[0] <= pwdata[5:0];
            pin_sel_q[1] <= pwdata[13:8];
            pin_sel_q[2] <= pwdata[21:16];
          end
          `SSP_OFF_RATE: begin
            rate_div_q <= pwdata[`SSP_RATE_MSB:0];
          end
          default: begin
            // status and unmapped writes are dropped
          end
        endcase
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // packet engine steering follows the mode directly
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bypass_q      <= 1'b0;
      fifo_bypass_q <= 1'b0;
      coding_q      <= 1'b1;
      msk_q         <= 1'b1;
      sync_hw_q     <= 1'b1;
      addr_q        <= 1'b1;
    end else begin
      bypass_q      <= async_mode;
      fifo_bypass_q <= serial_mode;
      coding_q      <= ~async_mode;
      msk_q         <= ~async_mode;
      // normal mode always frames; sync mode only when asked
      sync_hw_q     <= ~serial_mode | sync_hw;
      // no address filter in either serial mode
      addr_q        <= ~serial_mode;
    end
  end

  assign pkt_handler_bypass  = bypass_q;
  assign fifo_bypass         = fifo_bypass_q;
  assign coding_allowed      = coding_q;
  assign msk_allowed         = msk_q;
  assign preamble_sync_hw    = sync_hw_q;
  assign addr_filter_allowed = addr_q;

  // transmit path: async samples every eighth, sync once per bit
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_line_q    <= 8'h00;
      mod_bit_q    <= 1'b0;
      mod_strobe_q <= 1'b0;
    end else begin
      mod_strobe_q <= 1'b0;
      if (async_mode & tx_active & eighth_tick) begin
        // raw level straight through, host owns bit timing
        mod_bit_q    <= pin0_s2_q;
        mod_strobe_q <= 1'b1;
      end else if (sync_mode & tx_active & gate_open & rising_tick) begin
        // sample on the rising bit clock edge, emerge 8 bits later
        tx_line_q    <= {tx_line_q[6:0], pin0_s2_q};
        mod_bit_q    <= tx_line_q[`SSP_TX_LATENCY-1];
        mod_strobe_q <= 1'b1;
      end else if (!tx_active) begin
        tx_line_q <= 8'h00;
      end
    end
  end

  assign mod_tx_bit    = mod_bit_q;
  assign mod_tx_strobe = mod_strobe_q;

  // receive path: bit clock, latency line and symbol outputs
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_line_q  <= 9'h000;
      rx_cnt_q   <= 4'h0;
      sync_rx_q  <= 1'b0;
      async_rx_q <= 1'b0;
      bitclk_q   <= 1'b0;
      hard_q     <= 2'h0;
      symtick_q  <= 1'b0;
    end else begin
      if (!rx_active) begin
        // a fresh reception restarts the latency count
        rx_cnt_q  <= 4'h0;
        rx_line_q <= 9'h000;
      end else if (sync_mode & gate_open & rising_tick) begin
        rx_line_q <= {rx_line_q[7:0], rx_hard_sym[1]};
        if (!rx_valid) begin
          rx_cnt_q <= rx_cnt_q + 4'h1;
        end
      end
      if (eighth_tick) begin
        // raw level quantised to the eighth-bit grid, no decision
        async_rx_q <= async_mode & rx_raw_level;
        // clock low in the first half bit, high in the second
        // rises only at the sampling phase, so no host edge lacks a sample
        bitclk_q   <= sync_mode & gate_open & ph_n[2] & (bitclk_q | (ph_n == 3'h4));
        // strobe high for the first half of every symbol
        symtick_q  <= ~ph_n[2];
      end else if (!serial_mode) begin
        bitclk_q  <= 1'b0;
        symtick_q <= 1'b0;
      end
      if (falling_tick) begin
        // new data on the falling edge, host samples on rising
        sync_rx_q <= rx_valid & rx_line_q[`SSP_RX_LATENCY-1];
        hard_q    <= rx_hard_sym;
      end
    end
  end

  // per-pin function routing, pin 0 also handles tx direction
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
      reg out_d;
      reg oe_n_d;
      always @* begin
        out_d  = 1'b0;
        oe_n_d = 1'b0;
        case (pin_sel_q[gi])
          `SSP_FN_SER_DATA:   out_d = async_mode ? async_rx_q : sync_rx_q;
          `SSP_FN_SER_CLK:    out_d = bitclk_q;
          `SSP_FN_HARD1:      out_d = hard_q[1];
          `SSP_FN_HARD0:      out_d = hard_q[0];
          `SSP_FN_SYM_TICK:   out_d = symtick_q;
          `SSP_FN_PIN0_DIR_N: out_d = ~pin0_is_input;
          `SSP_FN_HIZ:        oe_n_d = 1'b1;
          `SSP_FN_LOW:        out_d = 1'b0;
          default:            out_d = 1'b0;
        endcase
        // pin 0 stops driving so the host can present tx data
        if ((gi == 0) && pin0_is_input) begin
          oe_n_d = 1'b1;
        end
      end
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          pin_out_q[gi]  <= 1'b0;
          pin_oe_n_q[gi] <= 1'b1;
        end else begin
          pin_out_q[gi]  <= out_d;
          pin_oe_n_q[gi] <= oe_n_d;
        end
      end
    end
  endgenerate

  assign general_pin_0_out   = pin_out_q[0];
  assign pin0_drive_enable_n = pin_oe_n_q[0];
  assign general_pin_1_out   = pin_out_q[1];
  assign pin1_drive_enable_n = pin_oe_n_q[1];
  assign general_pin_2_out   = pin_out_q[2];
  assign pin2_drive_enable_n = pin_oe_n_q[2];

endmodule // ssp_serial_port

/* File: design/ssp_tick_gen.v */
// eighth-bit tick generator with a three-bit phase within the bit.
// assumes clk is the crystal-derived clock and div comes from a register.
`timescale 1ns/1ps
`include "ssp_defines.vh"

module ssp_tick_gen (
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // control
  input  wire        enable,
  input  wire [15:0] div,
  // ticks
  output reg         eighth_tick_q,
  output reg  [2:0]  phase_q
);

  reg  [15:0] cnt_q;       // cycles counted so far in this eighth
  wire [15:0] div_eff;     // zero divider treated as one

  assign div_eff = (div == 16'h0000) ? 16'h0001 : div;

  // count up one eighth of a bit, then pulse and advance the phase
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q         <= 16'h0000;
      eighth_tick_q <= 1'b0;
      phase_q       <= 3'h0;
    end else if (!enable) begin
      // idle: restart cleanly so a new mode begins at bit start
      cnt_q         <= 16'h0000;
      eighth_tick_q <= 1'b0;
      phase_q       <= 3'h0;
    end else if (cnt_q >= div_eff - 16'h0001) begin
      cnt_q         <= 16'h0000;
      eighth_tick_q <= 1'b1;
      phase_q       <= phase_q + 3'h1;
    end else begin
      cnt_q         <= cnt_q + 16'h0001;
      eighth_tick_q <= 1'b0;
    end
  end

endmodule // ssp_tick_gen

/* File: inc/ssp_defines.vh */
// constants for the radio serial data port: register map, field layout,
// reset values and pin function codes.
// assumes inclusion by bare name from design files; definitions only.
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH

// apb register byte offsets
`define SSP_OFF_CTRL        12'h000
`define SSP_OFF_PINCFG      12'h004
`define SSP_OFF_RATE        12'h008
`define SSP_OFF_STATUS      12'h00c

// ctrl field positions
`define SSP_CTRL_FMT_LSB    0
`define SSP_CTRL_FMT_MSB    1
`define SSP_CTRL_SWM_LSB    2
`define SSP_CTRL_SWM_MSB    4

// pincfg field positions, one 6-bit select per pin, 8 bits apart
`define SSP_PINCFG_STRIDE   8
`define SSP_PINCFG_WIDTH    6

// rate field: clk cycles per eighth of a bit
`define SSP_RATE_MSB        15

// reset values
`define SSP_RST_FMT         2'h0
`define SSP_RST_SWM         3'h2
`define SSP_RST_PINSEL      6'h2e
`define SSP_RST_RATE        16'h0082

// packet format codes
`define SSP_FMT_NORMAL      2'h0
`define SSP_FMT_SYNC        2'h1
`define SSP_FMT_ASYNC       2'h3

// general pin function codes
`define SSP_FN_SER_CLK      6'h0c
`define SSP_FN_SER_DATA     6'h0d
`define SSP_FN_HARD1        6'h16
`define SSP_FN_HARD0        6'h17
`define SSP_FN_SYM_TICK     6'h1d
`define SSP_FN_PIN0_DIR_N   6'h2d
`define SSP_FN_HIZ          6'h2e
`define SSP_FN_LOW          6'h2f

// timing counts in bit periods and samples
`define SSP_SAMPLES_PER_BIT 4'h8
`define SSP_TX_LATENCY      8
`define SSP_RX_LATENCY      9
`define SSP_RX_CNT_FULL     4'h9

`endif

/* File: test/ssp_host_model.sv */
// host model: drives tx bits onto general pin 0.
// assumes bit_clk is the pin carrying the device bit clock.
`timescale 1ns/1ps
module ssp_host_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // mode and device bit clock
  input  wire logic       sync_mode,
  input  wire logic       bit_clk,
  // towards device
  output wire logic       tx_pin,
  output logic      [7:0] fall_cnt
);
  logic       a_bit;  // async level
  logic       s_bit;  // sync level
  logic       bclk_q; // sampled bit clock
  logic [2:0] aidx;   // async pattern index
  assign tx_pin = sync_mode ? s_bit : a_bit;
  // async stream on its own 320 ns bit time, phase unrelated to clk
  initial begin
    a_bit = 1'b0;
    aidx = 3'h0;
    #13;
    forever begin
      #320;
      aidx = aidx + 3'h1;
      a_bit = 1'(8'hb2 >> aidx);
    end
  end
  // sync: new bit just after each falling bit clock, a single one after fall 5
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bclk_q   <= 1'b0;
      fall_cnt <= 8'h0;
      s_bit    <= 1'b0;
    end else begin
      bclk_q <= bit_clk;
      if (sync_mode && bclk_q && !bit_clk) begin
        fall_cnt <= fall_cnt + 8'h1;
        s_bit    <= (fall_cnt == 8'h4);
      end
    end
  end
endmodule // ssp_host_model

/* File: test/ssp_serial_port_props.sv */
// checker for the serial port top: apb answer, steering, pin 0 direction.
// assumes the ssp_serial_port ports only; attached by bind below.
`timescale 1ns/1ps
module ssp_serial_port_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // radio, modulator and steering
  input wire logic        tx_active,
  input wire logic        general_pin_0_in,
  input wire logic        mod_tx_bit,
  input wire logic        mod_tx_strobe,
  input wire logic        pkt_handler_bypass,
  input wire logic        fifo_bypass,
  input wire logic        coding_allowed,
  input wire logic        msk_allowed,
  input wire logic        addr_filter_allowed,
  input wire logic        pin0_drive_enable_n,
  input wire logic        pin1_drive_enable_n,
  input wire logic        pin2_drive_enable_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_async_bypass: assert property (pkt_handler_bypass |-> fifo_bypass && !coding_allowed && !msk_allowed)
    else $error("async mode left coding or buffering on");
  a_serial_no_addr: assert property (fifo_bypass |-> !addr_filter_allowed)
    else $error("address filter allowed in serial mode");
  a_pin0_input_tx: assert property ((fifo_bypass && tx_active) [*4] |-> pin0_drive_enable_n)
    else $error("pin 0 driven while transmitting");
  // sync stages plus output flop: the bit lags the pin by three or four edges
  a_async_tx_level: assert property (mod_tx_strobe && pkt_handler_bypass |->
    mod_tx_bit == $past(general_pin_0_in, 3) || mod_tx_bit == $past(general_pin_0_in, 4))
    else $error("async tx bit does not follow pin 0");
  a_reset_idle: assert property ($rose(reset_n) |->
    pin0_drive_enable_n && pin1_drive_enable_n && pin2_drive_enable_n && !fifo_bypass)
    else $error("pins or mode not idle after reset");
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
endmodule // ssp_serial_port_props

bind ssp_serial_port ssp_serial_port_props u_props (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .tx_active(tx_active),
  .general_pin_0_in(general_pin_0_in), .mod_tx_bit(mod_tx_bit), .mod_tx_strobe(mod_tx_strobe),
  .pkt_handler_bypass(pkt_handler_bypass), .fifo_bypass(fifo_bypass),
  .coding_allowed(coding_allowed), .msk_allowed(msk_allowed),
  .addr_filter_allowed(addr_filter_allowed), .pin0_drive_enable_n(pin0_drive_enable_n),
  .pin1_drive_enable_n(pin1_drive_enable_n), .pin2_drive_enable_n(pin2_drive_enable_n));

/* File: test/testbench.sv */
// self-checking bench for the serial port: apb rows, then mode tests.
// assumes the host model drives pin 0; everything else driven here.
`timescale 1ns/1ps
module testbench;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        tx_active, rx_active, rx_raw_level, ph_payload_go, sync_mode, err;
  logic [1:0]  rx_hard_sym;
  logic        mod_tx_bit, mod_tx_strobe, pkt_handler_bypass, preamble_sync_hw;
  logic        pin0_in, p0o, p1o, p2o, p0e, p1e, p2e;
  logic [7:0]  fall_cnt;
  logic [5:0]  hist;
  int          failures, check_count, rises, r0, n;
  // apb rows: address, write data, expected read, expected error
  logic [76:0] rows [5] = '{{12'h000, 32'h1f, 32'h1f, 1'b0}, {12'h004, 32'h2d0d0c,
    32'h2d0d0c, 1'b0}, {12'h008, 32'hffff, 32'hffff, 1'b0}, {12'h010, 32'hffffffff,
    32'h0, 1'b1}, {12'hffc, 32'h5, 32'h0, 1'b1}};

  ssp_serial_port u_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_active(tx_active), .rx_active(rx_active),
    .rx_raw_level(rx_raw_level), .rx_hard_sym(rx_hard_sym), .ph_payload_go(ph_payload_go),
    .mod_tx_bit(mod_tx_bit), .mod_tx_strobe(mod_tx_strobe),
    .pkt_handler_bypass(pkt_handler_bypass), .fifo_bypass(), .coding_allowed(),
    .msk_allowed(), .preamble_sync_hw(preamble_sync_hw), .addr_filter_allowed(),
    .general_pin_0_in(pin0_in), .general_pin_0_out(p0o), .pin0_drive_enable_n(p0e),
    .general_pin_1_out(p1o), .pin1_drive_enable_n(p1e), .general_pin_2_out(p2o),
    .pin2_drive_enable_n(p2e));
  ssp_host_model u_host (.clk(clk), .reset_n(reset_n), .sync_mode(sync_mode),
    .bit_clk(p1o), .tx_pin(pin0_in), .fall_cnt(fall_cnt));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // rising bit clock edges seen on pin 1 in sync mode
  always @(posedge p1o) if (sync_mode) rises++;

  task chk(input logic [31:0] exp, input logic [31:0] act);
    check_count++;
    if (act !== exp) begin
      failures++;
      $display("Error at %0t: expected %h got %h", $time, exp, act);
    end
  endtask
  // one apb transfer, then an idle cycle; ready is sampled at rising edges
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk); penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin n++; @(posedge clk); end
    if (n == 20) chk(32'h1, pready);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task reset_check;
    reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk(32'h7, {p0e, p1e, p2e});
    apb(1'b0, 12'h000, 32'h0); chk(32'h8, rd);
    apb(1'b0, 12'h004, 32'h0); chk(32'h2e2e2e, rd);
    apb(1'b0, 12'h008, 32'h0); chk(32'h82, rd);
    $display("test reset done");
  endtask

  initial begin
    {reset_n, psel, penable, pwrite, tx_active, rx_active, rx_raw_level} = '0;
    {ph_payload_go, sync_mode, rx_hard_sym, paddr, pwdata} = '0;
    {failures, check_count, rises} = '0;
    @(posedge clk);
    reset_check();
    foreach (rows[i]) begin
      apb(1'b1, rows[i][76:65], rows[i][64:33]); chk(rows[i][0], err);
      apb(1'b0, rows[i][76:65], 32'h0); chk(rows[i][32:1], rd); chk(rows[i][0], err);
    end
    $display("test rows done");
    // sync tx: one marked bit, latency counted in bit clock rises
    sync_mode <= 1'b1; tx_active <= 1'b1;
    apb(1'b1, 12'h004, 32'h0d0c2e); apb(1'b1, 12'h008, 32'h2);
    apb(1'b1, 12'h000, 32'h1);
    n = 0;
    while (mod_tx_bit !== 1'b1 && n < 600) begin n++; @(posedge clk); end
    repeat (4) @(posedge clk);
    chk(32'd14, rises);
    chk(32'h1, {preamble_sync_hw, p0e});
    chk(32'd13, fall_cnt);
    $display("test sync tx done");
    // sync rx: constant one, appears after nine bit clock rises
    tx_active <= 1'b0; rx_hard_sym <= 2'b10;
    r0 = rises;
    while (rises == r0) @(posedge clk);
    repeat (4) @(posedge clk);
    r0 = rises; rx_active <= 1'b1; n = 0;
    while (p2o !== 1'b1 && n < 600) begin n++; @(posedge clk); end
    repeat (4) @(posedge clk);
    chk(32'd9, rises - r0);
    $display("test sync rx done");
    // sync word hardware holds the bit clock until payload go
    rx_active <= 1'b0;
    apb(1'b1, 12'h000, 32'h9);
    repeat (4) @(posedge clk);
    r0 = rises;
    repeat (64) @(posedge clk);
    chk(r0, rises);
    chk(1'b1, preamble_sync_hw);
    ph_payload_go <= 1'b1;
    repeat (64) @(posedge clk);
    chk(1'b1, rises > r0);
    $display("test sync gate done");
    // async tx: pin 0 level follows at eight samples per bit
    sync_mode <= 1'b0; ph_payload_go <= 1'b0; tx_active <= 1'b1;
    apb(1'b1, 12'h008, 32'h1); apb(1'b1, 12'h004, 32'h0d2d2e); apb(1'b1, 12'h000, 32'h3);
    repeat (8) @(posedge clk);
    hist = '0; r0 = 0;
    repeat (64) begin
      @(negedge clk);
      hist = {hist[4:0], pin0_in};
      r0 += mod_tx_strobe;
      if (hist == 6'h0 || hist == 6'h3f) chk(hist[0], mod_tx_bit);
    end
    chk(32'd64, r0);
    chk(32'h6, {pkt_handler_bypass, p0e, p1o});
    // async rx: raw level on the selected pin, read once settled
    @(posedge clk);
    tx_active <= 1'b0; rx_active <= 1'b1; rx_raw_level <= 1'b1;
    repeat (6) @(posedge clk);
    chk(1'b1, p2o);
    rx_raw_level <= 1'b0;
    repeat (6) @(posedge clk);
    chk(1'b0, p2o);
    $display("test async done");
    // symbol tick and hard symbol bits on the pins
    apb(1'b1, 12'h004, 32'h17161d);
    repeat (16) @(posedge clk);
    r0 = 0;
    repeat (16) begin @(negedge clk); r0 += p0o; end
    chk(32'd8, r0);
    chk(32'h2, {p0e, p1o, p2o});
    $display("test pins done");
    @(posedge clk);
    rx_active <= 1'b0;
    reset_check();
    end_of_test();
  end
  // watchdog, far beyond the expected run of under a thousand cycles
  initial begin
    #800000;
    failures++;
    end_of_test();
  end
endmodule // testbench
